// ===== shared/spi_port_pkg.sv
// Constants shared by the serial port control and status logic
package spi_port_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int DIV_W = 8;
    localparam int FIFO_DEPTH = 4;

    // Register addresses
    localparam logic [31:0] ADDR_STATUS = 32'hffff0a00;
    localparam logic [31:0] ADDR_RX = 32'hffff0a04;
    localparam logic [31:0] ADDR_TX = 32'hffff0a08;
    localparam logic [31:0] ADDR_DIV = 32'hffff0a0c;
    localparam logic [31:0] ADDR_CTRL = 32'hffff0a10;

    // Control field positions
    localparam int CTL_EN = 0;
    localparam int CTL_MASTER = 1;
    localparam int CTL_PHASE = 2;
    localparam int CTL_POL = 3;
    localparam int CTL_LSB = 5;
    localparam int CTL_TXMODE = 6;
    localparam int CTL_UFLOW = 7;
    localparam int CTL_OVWR = 8;
    localparam int CTL_SSEN = 9;

    // Status field positions
    localparam int ST_TXBUSY = 0;
    localparam int ST_TXIRQ = 1;
    localparam int ST_TXUFL = 2;
    localparam int ST_RXFULL = 3;
    localparam int ST_RXIRQ = 4;
    localparam int ST_RXOVF = 5;

    // Reset values and masks
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_MASK = 16'h03ef;
    localparam logic [7:0] DIV_RESET = 8'h1b;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] RX_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Bit and edge counts per byte
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_FULL = 4'h8;
    localparam logic [4:0] EDGE_LAST = 5'h0f;
endpackage : spi_port_pkg

// ===== hdl/spi_byte_fifo.sv
// Small FIFO for bytes waiting to be shifted out
`timescale 1ns/1ns
module spi_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic push;
    logic pop;

    assign in_ready = (count_r != FULL_CNT);
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (ce && push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else if (ce) begin
            if (flush) begin
                wr_ptr_r <= '0;
                rd_ptr_r <= '0;
                count_r <= '0;
            end else begin
                if (push) begin
                    wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
                end
                if (pop) begin
                    rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
                end
                if (push && !pop) begin
                    count_r <= count_r + 1'b1;
                end else if (pop && !push) begin
                    count_r <= count_r - 1'b1;
                end
            end
        end
    end
endmodule : spi_byte_fifo

// ===== hdl/spi_half_tick.sv
// Half-period tick generator for the master serial clock
`timescale 1ns/1ns
module spi_half_tick #(
    parameter int DIV_W = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic run,
    input wire logic [DIV_W-1:0] div,
    output logic tick
);
    logic [DIV_W-1:0] cnt_r;

    // half period is one plus divider
    assign tick = run && (cnt_r == div);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (ce) begin
            if (!run || tick) begin
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end
endmodule : spi_half_tick

// ===== hdl/spi_port_control_status.sv
// Serial port control, status and receive logic, master or slave
// Functional notes
// - Master drives chip select when enabled
// - Full receive register: overwrite or drop byte
// - Underflow resends last byte or zero
// - Transmit-write start, interrupt on transmit empty
// - Receive-read start, interrupt on receive full
// - Bit order LSB or MSB first
// - Clock idle level follows polarity bit
// - Phase bit picks leading or trailing pulse
// - Master drives clock, slave accepts it
// - Port works only while enabled
// - Overflow flag set, cleared by receive read
// - Receive interrupt follows full or overflow
// - Receive full flag, cleared by read
// - Underflow flag, cleared by transmit write
// - Transmit interrupt on empty or underflow
// - Transmit busy while data queued or a queued byte shifting
// - Status is read-only, reserved bits zero
// - Receive register holds last accepted byte
// - Clock rate set by divider register
// - Drive on one edge, sample other
`timescale 1ns/1ns
module spi_port_control_status (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic [spi_port_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [spi_port_pkg::DATA_W-1:0] reg_wdata,
    output logic [spi_port_pkg::DATA_W-1:0] reg_rdata,
    output logic tx_ready,
    output logic spi_irq,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    input wire logic ss_n_in,
    output logic ss_n_out,
    output logic ss_n_oe
);
    import spi_port_pkg::*;

    typedef enum logic [3:0] {
        M_IDLE = 4'b0001,
        M_SETUP = 4'b0010,
        M_SHIFT = 4'b0100,
        M_HOLD = 4'b1000
    } mstate_t;

    mstate_t mstate_r;
    logic [15:0] ctrl_r;
    logic [7:0] div_r;
    logic [7:0] rx_data_r;
    logic [7:0] tx_sh_r;
    logic [7:0] rx_sh_r;
    logic [7:0] last_tx_r;
    logic [3:0] bit_cnt_r;
    logic [4:0] edge_cnt_r;
    logic sclk_r;
    logic ss_r;
    logic sclk_prev_r;
    logic ss_prev_r;
    logic busy_r;
    logic busy_prev_r;
    logic rx_full_r;
    logic rx_ovf_r;
    logic rx_irq_r;
    logic tx_ufl_r;
    logic tx_irq_r;

    logic enable;
    logic master;
    logic cpha;
    logic cpol;
    logic lsb;
    logic txmode;
    logic ufl_mode;
    logic ovwr;
    logic ss_en;
    logic sel_status;
    logic sel_rx;
    logic sel_tx;
    logic sel_div;
    logic sel_ctrl;
    logic wr_tx;
    logic rd_rx;
    logic tick;
    logic m_edge;
    logic m_start;
    logic s_frame;
    logic s_chg;
    logic s_start;
    logic lead;
    logic trail;
    logic sample;
    logic launch;
    logic in_bit;
    logic out_bit;
    logic load_now;
    logic ufl_evt;
    logic byte_done;
    logic tx_busy;
    logic rx_keep_old;
    logic disable_idle;
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic [7:0] load_byte;
    logic [7:0] rx_byte_nxt;
    logic [7:0] status_word;

    assign enable = ctrl_r[CTL_EN];
    assign master = ctrl_r[CTL_MASTER];
    assign cpha = ctrl_r[CTL_PHASE];
    assign cpol = ctrl_r[CTL_POL];
    assign lsb = ctrl_r[CTL_LSB];
    assign txmode = ctrl_r[CTL_TXMODE];
    assign ufl_mode = ctrl_r[CTL_UFLOW];
    assign ovwr = ctrl_r[CTL_OVWR];
    assign ss_en = ctrl_r[CTL_SSEN];

    assign sel_status = (reg_addr == ADDR_STATUS);
    assign sel_rx = (reg_addr == ADDR_RX);
    assign sel_tx = (reg_addr == ADDR_TX);
    assign sel_div = (reg_addr == ADDR_DIV);
    assign sel_ctrl = (reg_addr == ADDR_CTRL);
    assign wr_tx = reg_wr && sel_tx;
    assign rd_rx = reg_rd && sel_rx;

    // Control and divider registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_r <= CTRL_RESET;
        end else if (ce && reg_wr && sel_ctrl) begin
            ctrl_r <= reg_wdata & CTRL_MASK;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_r <= DIV_RESET;
        end else if (ce && reg_wr && sel_div) begin
            div_r <= reg_wdata[7:0];
        end
    end

    // Transmit byte queue
    spi_byte_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .flush(!enable),
        .in_valid(wr_tx),
        .in_ready(tx_ready),
        .in_data(reg_wdata[7:0]),
        .out_valid(fifo_valid),
        .out_ready(load_now),
        .out_data(fifo_data)
    );

    spi_half_tick #(
        .DIV_W(DIV_W)
    ) u_half_tick (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .run(mstate_r != M_IDLE),
        .div(div_r),
        .tick(tick)
    );

    assign m_start = enable && master && (mstate_r == M_IDLE)
                     && (txmode ? fifo_valid : rd_rx);
    assign m_edge = (mstate_r == M_SHIFT) && tick;

    // Slave frame and clock edge detection
    assign s_frame = enable && !master && !ss_n_in;
    assign s_chg = (sclk_in != sclk_prev_r);
    assign s_start = enable && !master && !ss_n_in && ss_prev_r;

    assign lead = master ? (m_edge && !edge_cnt_r[0])
                         : (s_frame && s_chg && (sclk_in != cpol));
    assign trail = master ? (m_edge && edge_cnt_r[0])
                          : (s_frame && s_chg && (sclk_in == cpol));
    // phase picks launch and sample edges
    assign sample = cpha ? trail : lead;
    assign launch = cpha ? lead : trail;
    assign in_bit = master ? miso_in : mosi_in;

    assign load_now = m_start || s_start
                      || (launch && !master && (bit_cnt_r == BIT_FULL));
    assign ufl_evt = load_now && !fifo_valid;
    assign load_byte = fifo_valid ? fifo_data
                                  : (ufl_mode ? last_tx_r : ZERO_BYTE);

    assign out_bit = lsb ? tx_sh_r[0] : tx_sh_r[7];
    assign rx_byte_nxt = lsb ? {in_bit, rx_sh_r[7:1]}
                             : {rx_sh_r[6:0], in_bit};
    assign byte_done = sample && (bit_cnt_r == BIT_LAST);

    // Master sequencer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mstate_r <= M_IDLE;
            edge_cnt_r <= '0;
        end else if (ce) begin
            if (!enable || !master) begin
                mstate_r <= M_IDLE;
                edge_cnt_r <= '0;
            end else begin
                unique case (mstate_r)
                    M_IDLE: begin
                        edge_cnt_r <= '0;
                        if (m_start) begin
                            mstate_r <= M_SETUP;
                        end
                    end
                    M_SETUP: begin
                        if (tick) begin
                            mstate_r <= M_SHIFT;
                        end
                    end
                    M_SHIFT: begin
                        if (tick) begin
                            edge_cnt_r <= edge_cnt_r + 1'b1;
                            if (edge_cnt_r == EDGE_LAST) begin
                                mstate_r <= M_HOLD;
                            end
                        end
                    end
                    M_HOLD: begin
                        if (tick) begin
                            mstate_r <= M_IDLE;
                        end
                    end
                    default: begin
                        mstate_r <= M_IDLE;
                    end
                endcase
            end
        end
    end

    // Serial clock and chip select drive
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sclk_r <= 1'b0;
            ss_r <= 1'b1;
        end else if (ce) begin
            if (mstate_r == M_IDLE) begin
                sclk_r <= cpol;
            end else if (m_edge) begin
                sclk_r <= !sclk_r;
            end
            ss_r <= !(m_start || (mstate_r != M_IDLE && !m_start
                      && !(mstate_r == M_HOLD && tick)));
        end
    end

    // Slave pin history
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sclk_prev_r <= 1'b0;
            ss_prev_r <= 1'b1;
        end else if (ce) begin
            sclk_prev_r <= sclk_in;
            ss_prev_r <= ss_n_in;
        end
    end

    // Transmit shifter
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_sh_r <= ZERO_BYTE;
            last_tx_r <= ZERO_BYTE;
        end else if (ce) begin
            if (!enable) begin
                tx_sh_r <= ZERO_BYTE;
            end else if (load_now) begin
                tx_sh_r <= load_byte;
                last_tx_r <= load_byte;
            end else if (launch && !(cpha && bit_cnt_r == '0)) begin
                tx_sh_r <= lsb ? {1'b0, tx_sh_r[7:1]}
                               : {tx_sh_r[6:0], 1'b0};
            end
        end
    end

    // Receive shifter and bit count
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_sh_r <= ZERO_BYTE;
            bit_cnt_r <= '0;
        end else if (ce) begin
            if (!enable || (!master && ss_n_in)) begin
                bit_cnt_r <= '0;
            end else if (load_now) begin
                bit_cnt_r <= '0;
            end else if (sample) begin
                rx_sh_r <= rx_byte_nxt;
                bit_cnt_r <= bit_cnt_r + 1'b1;
            end
        end
    end

    assign tx_busy = fifo_valid || busy_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_r <= 1'b0;
            busy_prev_r <= 1'b0;
        end else if (ce) begin
            if (!enable) begin
                busy_r <= 1'b0;
            end else if (load_now) begin
                busy_r <= fifo_valid;
            end else if (byte_done) begin
                busy_r <= 1'b0;
            end
            busy_prev_r <= tx_busy;
        end
    end

    // drop only when still full after read
    assign rx_keep_old = rx_full_r && !rd_rx && !ovwr;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_data_r <= RX_RESET;
        end else if (ce && byte_done && !rx_keep_old) begin
            rx_data_r <= rx_byte_nxt;
        end
    end

    // flags set on edge, set beats clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_full_r <= 1'b0;
            rx_ovf_r <= 1'b0;
            rx_irq_r <= 1'b0;
        end else if (ce) begin
            if (byte_done) begin
                rx_full_r <= 1'b1;
            end else if (rd_rx) begin
                rx_full_r <= 1'b0;
            end
            if (byte_done && rx_full_r && !rd_rx) begin
                rx_ovf_r <= 1'b1;
            end else if (rd_rx) begin
                rx_ovf_r <= 1'b0;
            end
            if (byte_done) begin
                rx_irq_r <= 1'b1;
            end else if (rd_rx) begin
                rx_irq_r <= 1'b0;
            end
        end
    end

    assign disable_idle = reg_wr && sel_ctrl && !reg_wdata[CTL_EN]
                          && !tx_busy;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_ufl_r <= 1'b0;
            tx_irq_r <= 1'b0;
        end else if (ce) begin
            if (ufl_evt) begin
                tx_ufl_r <= 1'b1;
            end else if (wr_tx) begin
                tx_ufl_r <= 1'b0;
            end
            if ((busy_prev_r && !tx_busy) || ufl_evt) begin
                tx_irq_r <= 1'b1;
            end else if (wr_tx || disable_idle) begin
                tx_irq_r <= 1'b0;
            end
        end
    end

    assign status_word = {2'b00, rx_ovf_r, rx_irq_r, rx_full_r,
                          tx_ufl_r, tx_irq_r, tx_busy};

    // Register read port, write-only and unmapped read zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (ce && reg_rd) begin
            if (sel_status) begin
                reg_rdata <= {8'h00, status_word};
            end else if (sel_rx) begin
                reg_rdata <= {8'h00, rx_data_r};
            end else if (sel_div) begin
                reg_rdata <= {8'h00, div_r};
            end else if (sel_ctrl) begin
                reg_rdata <= ctrl_r;
            end else begin
                reg_rdata <= '0;
            end
        end
    end

    assign spi_irq = (master && txmode) ? tx_irq_r : rx_irq_r;

    // master drives clock and data out
    assign sclk_out = sclk_r;
    assign sclk_oe = enable && master;
    assign mosi_out = master && out_bit;
    assign mosi_oe = enable && master;
    assign miso_out = !master && out_bit;
    assign miso_oe = enable && !master && !ss_n_in;
    assign ss_n_out = ss_r;
    assign ss_n_oe = enable && master && ss_en;
endmodule : spi_port_control_status

// ===== testbench/spi_port_checker.sv
// Port assertions for the serial port control and status block
`timescale 1ns/1ns
module spi_port_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic [spi_port_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [spi_port_pkg::DATA_W-1:0] reg_rdata,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    input wire logic ss_n_in,
    input wire logic ss_n_out,
    input wire logic ss_n_oe
);
    import spi_port_pkg::*;
    logic [4:0] edge_cnt_r;
    logic sclk_d_r;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence rd_at(logic [31:0] a);
        ce && reg_rd && reg_addr == a;
    endsequence
    // Serial clock edges inside one frame
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            edge_cnt_r <= 5'h00;
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_out;
            if (ss_n_out) begin
                edge_cnt_r <= 5'h00;
            end else if (sclk_out != sclk_d_r) begin
                edge_cnt_r <= edge_cnt_r + 5'h01;
            end
        end
    end
    a_unmapped_zero: assert property (
        rd_at(32'hffff0a14) |=> reg_rdata == 16'h0000)
        else $error("Unmapped read returned data");
    a_status_reserved: assert property (
        rd_at(ADDR_STATUS) |=> reg_rdata[15:6] == 10'h000)
        else $error("Status reserved bits set");
    a_rx_byte_wide: assert property (
        rd_at(ADDR_RX) |=> reg_rdata[15:8] == 8'h00)
        else $error("Receive read upper byte set");
    a_ctrl_masked: assert property (
        rd_at(ADDR_CTRL) |=> (reg_rdata & ~CTRL_MASK) == 16'h0000)
        else $error("Control reserved bits set");
    a_rdata_hold: assert property (
        !$past(reg_rd) |-> $stable(reg_rdata))
        else $error("Read data moved without a read");
    a_select_master: assert property (
        ss_n_oe |-> sclk_oe && mosi_oe && !miso_oe)
        else $error("Select driven outside master mode");
    a_slave_out: assert property (
        miso_oe |-> !ss_n_in && !sclk_oe && !mosi_oe)
        else $error("Slave output without select");
    a_frame_edges: assert property (
        $rose(ss_n_out) |-> edge_cnt_r == 5'h10)
        else $error("Frame without sixteen clock edges");
endmodule : spi_port_checker

bind spi_port_control_status spi_port_checker spi_port_checker_i (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
    .ss_n_in(ss_n_in), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe)
);

// ===== testbench/spi_slave_model.sv
// Behavioural external serial slave device
`timescale 1ns/1ns
module spi_slave_model (
    input wire logic sclk,
    input wire logic mosi,
    input wire logic ss_n,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    logic [7:0] sh_r;
    initial miso = 1'b0;
    // Select loads the outgoing byte
    always @(negedge ss_n) begin
        sh_r = tx_byte;
        rx_byte = 8'h00;
        miso = cpha ? ~tx_byte[7] : tx_byte[7];
    end
    // Released line shows the inverse level
    always @(posedge ss_n) miso = ~miso;
    // edge roles from polarity and phase
    always @(sclk) begin
        if (!ss_n && ((sclk != cpol) ^ cpha)) begin
            rx_byte = {rx_byte[6:0], mosi};
        end else if (!ss_n && cpha) begin
            miso = sh_r[7];
            sh_r = sh_r << 1;
        end else if (!ss_n) begin
            sh_r = sh_r << 1;
            miso = sh_r[7];
        end
    end
endmodule : spi_slave_model

// ===== testbench/spi_port_control_status_tb.sv
// Self-checking bench for the serial port control and status block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
    logic [15:0] ev_m; \
    ev_m = (e); \
    n_checks++; \
    if ((g) !== ev_m) begin \
        n_mismatch++; \
        $display("BAD %s exp %h got %h", nm, ev_m, g); \
    end \
end
module spi_port_control_status_tb;
    import spi_port_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [31:0] reg_addr = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_d = 1'b0;
    logic ss_n_in = 1'b1;
    logic sclk_in = 1'b0;
    logic mosi_in = 1'b0;
    logic [15:0] reg_wdata = 16'h0;
    logic [15:0] reg_rdata;
    logic tx_ready, spi_irq, sclk_out, sclk_oe, mosi_out, mosi_oe;
    logic miso_out, miso_oe, ss_n_out, ss_n_oe, miso;
    logic cpol = 1'b0, cpha = 1'b0, lsb = 1'b0;
    logic [7:0] mtx = 8'h00, rx_byte, t, r8;
    logic [15:0] exp_q[$];
    logic [7:0] mq[$];
    int n_mismatch = 0, n_checks = 0, n_frames = 0, n;
    always #10 clk_sys = ~clk_sys;
    spi_port_control_status spi_port_control_status_i (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .tx_ready(tx_ready), .spi_irq(spi_irq),
        .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
        .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
        .miso_in(miso), .miso_out(miso_out), .miso_oe(miso_oe),
        .ss_n_in(ss_n_in), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe));
    spi_slave_model spi_slave_model_i (
        .sclk(sclk_out), .mosi(mosi_out), .ss_n(ss_n_out), .cpol(cpol),
        .cpha(cpha), .tx_byte(mtx), .miso(miso), .rx_byte(rx_byte));
    function automatic logic [7:0] rev(input logic [7:0] b);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7 - i];
        end
        return r;
    endfunction : rev
    task automatic end_of_test();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic rd(input logic [31:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask : rd
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic frames(input int k);
        int goal;
        goal = n_frames + k;
        for (int i = 0; i < 600 * k && n_frames < goal; i++) begin
            @(posedge clk_sys);
        end
        if (n_frames < goal) begin
            n_mismatch++;
            end_of_test();
        end
        repeat (2) @(posedge clk_sys);
    endtask : frames
    task automatic xfer();
        mtx = 8'($urandom);
        t = 8'($urandom);
        mq.push_back(lsb ? rev(t) : t);
        wr(ADDR_TX, {8'h00, t});
        frames(1);
    endtask : xfer
    always @(posedge clk_sys) begin
        rd_d <= reg_rd;
        if (rd_d) begin
            `CHK("reg_rdata", exp_q.pop_front(), reg_rdata)
        end
    end
    always @(posedge ss_n_out) begin
        if (!rst) begin
            n_frames++;
            `CHK("model_rx", mq.pop_front(), rx_byte)
        end
    end
    initial begin
        void'($urandom(30885));
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        rd(ADDR_STATUS, STATUS_RESET);
        rd(ADDR_RX, 16'h0000);
        rd(ADDR_CTRL, 16'h0000);
        rd(ADDR_DIV, {8'h00, DIV_RESET});
        rd(32'hffff0a14, 16'h0000);
        wr(ADDR_STATUS, 16'hffff);
        wr(ADDR_RX, 16'hffff);
        rd(ADDR_STATUS, 16'h0000);
        rd(ADDR_RX, 16'h0000);
        wr(ADDR_CTRL, 16'hffff);
        rd(ADDR_CTRL, CTRL_MASK);
        wr(ADDR_DIV, 16'h0000);
        for (int m = 0; m < 8; m++) begin
            {lsb, cpol, cpha} = 3'(m);
            wr(ADDR_CTRL, 16'h0243 | {10'h0, lsb, 1'b0, cpol, cpha, 2'b0});
            xfer();
            `CHK("spi_irq", 1'b1, spi_irq)
            rd(ADDR_STATUS, 16'h001a);
            rd(ADDR_RX, {8'h00, (lsb ? rev(mtx) : mtx)});
        end
        {lsb, cpol, cpha} = 3'b000;
        wr(ADDR_CTRL, 16'h0283);
        r8 = rev(mtx);
        mtx = 8'($urandom);
        mq.push_back(t);
        rd(ADDR_RX, {8'h00, r8});
        frames(1);
        `CHK("spi_irq", 1'b1, spi_irq)
        rd(ADDR_STATUS, 16'h001e);
        wr(ADDR_CTRL, 16'h0203);
        r8 = mtx;
        mtx = 8'($urandom);
        mq.push_back(8'h00);
        rd(ADDR_RX, {8'h00, r8});
        frames(1);
        wr(ADDR_CTRL, 16'h0243);
        rd(ADDR_RX, {8'h00, mtx});
        xfer();
        r8 = mtx;
        xfer();
        rd(ADDR_STATUS, 16'h003a);
        rd(ADDR_RX, {8'h00, r8});
        rd(ADDR_STATUS, 16'h0002);
        wr(ADDR_CTRL, 16'h0343);
        xfer();
        xfer();
        rd(ADDR_RX, {8'h00, mtx});
        wr(ADDR_DIV, 16'h0002);
        n = 0;
        while (tx_ready === 1'b1 && n < 8) begin
            t = 8'($urandom);
            mq.push_back(t);
            wr(ADDR_TX, {8'h00, t});
            n++;
            #2;
        end
        `CHK("tx_ready", 1'b0, tx_ready)
        frames(n);
        `CHK("tx_ready", 1'b1, tx_ready)
        rd(ADDR_RX, {8'h00, mtx});
        wr(ADDR_CTRL, 16'h0000);
        rd(ADDR_STATUS, 16'h0000);
        `CHK("sclk_oe", 1'b0, sclk_oe)
        wr(ADDR_CTRL, 16'h0001);
        t = 8'($urandom);
        mtx = 8'($urandom);
        wr(ADDR_TX, {8'h00, t});
        ss_n_in <= 1'b0;
        repeat (3) @(posedge clk_sys);
        `CHK("miso_oe", 1'b1, miso_oe)
        for (int i = 0; i < 8; i++) begin
            mosi_in <= mtx[7 - i];
            repeat (2) @(posedge clk_sys);
            r8 = {r8[6:0], miso_out};
            sclk_in <= 1'b1;
            repeat (2) @(posedge clk_sys);
            sclk_in <= 1'b0;
        end
        repeat (2) @(posedge clk_sys);
        ss_n_in <= 1'b1;
        `CHK("miso_out", t, r8)
        rd(ADDR_RX, {8'h00, mtx});
        repeat (2) @(posedge clk_sys);
        end_of_test();
    end
endmodule : spi_port_control_status_tb
